// File: design/mpk_map.vh
// constants for the multirail pwm phase and kick-start block
// included by the design files; holds definitions only
`ifndef MPK_MAP_VH
`define MPK_MAP_VH

// register byte offsets
`define MPK_OFF_CTRL      6'h00
`define MPK_OFF_RAIL_MAP  6'h04
`define MPK_OFF_PERIOD0   6'h08
`define MPK_OFF_MIN_DUTY  6'h18
`define MPK_OFF_VSTART    6'h1C
`define MPK_OFF_VTARGET   6'h20
`define MPK_OFF_RAMP_STEP 6'h24
`define MPK_OFF_STATUS    6'h28

// control bits
`define MPK_CTRL_SS_GO    0
`define MPK_CTRL_RESYNC   1

// status fields
`define MPK_ST_STATE_LSB  0
`define MPK_ST_CHAIN      4
`define MPK_ST_SRE        5
`define MPK_ST_DAC_LSB    16

// reset values
`define MPK_RST_PERIOD    16'h00C8
`define MPK_RST_RAIL_MAP  8'hE4
`define MPK_RST_MIN_DUTY  16'h0004
`define MPK_RST_STEP      12'h001

// phase spreading between rails, in thirteenths
`define MPK_RAIL_NUM      18'h00003
`define MPK_RAIL_DEN      18'h0000D

// timing and analogue scaling
`define MPK_CLK_HZ        100000000
`define MPK_DAC_RATE_HZ   10000
`define MPK_DAC_LSB_UV    1600
`define MPK_EADC_RANGE_MV 64

`endif

// File: design/mpk_pwm_engine.v
// one pwm engine: free-running ramp counter, compare, delayed chain reset
// assumes period >= 1 and a single master clock shared by all engines
`timescale 1ns/10ps
`include "mpk_map.vh"

module mpk_pwm_engine
(
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // configuration
    input  wire [15:0] period,
    input  wire [15:0] duty,
    input  wire [17:0] nextDelay,
    // chain
    input  wire        syncIn,
    input  wire        chainEn,
    output reg         syncOut,
    // output
    output reg         pwm
);

reg  [15:0] count_q;
reg  [17:0] dly_q;
reg         armed_q;

always @(posedge clk)
begin
    if (rst)
    begin
        count_q <= 16'h0000;
        pwm     <= 1'b0;
    end
    else
    begin
        // [R3] chained reset clears ramp
        if (syncIn)
            count_q <= 16'h0000;
        else if (count_q >= period - 16'h0001)
            count_q <= 16'h0000;
        else
            count_q <= count_q + 16'h0001;
        pwm <= (count_q < duty);
    end
end

always @(posedge clk)
begin
    if (rst)
    begin
        armed_q <= 1'b0;
        dly_q   <= 18'h00000;
        syncOut <= 1'b0;
    end
    else
    begin
        syncOut <= 1'b0;
        // [R5] delay only armed in chain
        if (syncIn && chainEn)
        begin
            armed_q <= 1'b1;
            dly_q   <= nextDelay;
        end
        // [R14] delay in whole ticks
        else if (armed_q)
        begin
            if (dly_q == 18'h00000)
            begin
                armed_q <= 1'b0;
                syncOut <= 1'b1;
            end
            else
                dly_q <= dly_q - 18'h00001;
        end
    end
end

endmodule // mpk_pwm_engine

// File: design/mpk_top.v
// multirail pwm timing with phase-spreading reset chain and kick-start
// assumes engines of one rail are contiguous and rails appear in order
//
// Behaviour
// [R1] the first stage of each next rail lags the previous rail's first stage by 3/13 of the fastest period.
// [R2] phase k of an N-stage rail lags its phase 0 by k/N of the rail period.
// [R3] each engine issues a delayed reset pulse that clears the next engine's ramp counter.
// [R4] the chain reset runs at power-up and on any change of rail mapping or switching period.
// [R5] after the chain the delayed resets are disabled and counters run freely.
// [R6] switching stays off until the soft-start ramp reaches the start voltage.
// [R7] during kick-start both clamps equal the minimum pulse duty, giving a fixed pulse.
// [R8] the reference dac takes the start voltage as the clamps are applied.
// [R9] when the error adc leaves saturation both clamps release and the loop closes.
// [R10] software should avoid a long minimum pulse at low output ratio or high frequency.
// [R11] kick-start lasts until the output is within the error adc range.
// [R12] pwm and rectifier enable stay off before kick-start and turn on at its start.
// [R13] after loop closure the reference dac steps to target at 10 kHz, one code per step.
// [R14] all counters run from one master clock with phase delays in whole ticks.
`timescale 1ns/10ps
`include "mpk_map.vh"

module mpk_top
#(
    parameter DAC_TICK_CYCLES = `MPK_CLK_HZ / `MPK_DAC_RATE_HZ
)
(
    // clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // avalon-mm slave
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // loop
    input  wire [15:0] compDuty,
    input  wire        eadcSat,
    output reg  [11:0] refDac,
    // power stage
    output reg  [3:0]  pwmOut,
    output reg         sync_rectifier_enable
);

localparam NENG = 4;
localparam [2:0] SS_IDLE = 3'h0, SS_WAIT = 3'h1, SS_KICK = 3'h2,
                 SS_CLOSED = 3'h3, SS_DONE = 3'h4;

reg  [7:0]  railMap_q;
reg  [15:0] period_q [0:3];
reg  [15:0] minDuty_q, vStart_q, vTarget_q;
reg  [11:0] rampStep_q, idealRamp_q;
reg  [2:0]  ss_q;
reg         kickPend_q, chainKick_q, chainEn_q;
reg  [13:0] tick_q;
reg         satS1_q, satS2_q, satS3_q, sat_q;
integer     i, j, r;

wire [NENG:0] sync;
wire [NENG-1:0] pwmRaw;
reg  [17:0] off [0:NENG-1];
reg  [17:0] nextDly [0:NENG-1];
reg  [15:0] fast;
reg  [17:0] railGap;
reg  [2:0]  kIdx, nPh;
reg  [1:0]  ord;
reg  [17:0] kp, share, diff;
reg  [15:0] dutyEff;
wire        tick = (tick_q == 14'h0000);
wire        hit  = avs_waitrequest == 1'b0;

// bus: one wait cycle, taken at the edge where waitrequest is low
always @(posedge core_clk)
begin
    if (rst)
    begin
        avs_waitrequest <= 1'b1;
        avs_readdata    <= 32'h00000000;
    end
    else
    begin
        avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        if (avs_read && avs_waitrequest)
        begin
            case ({avs_address[5:2], 2'b00})
                `MPK_OFF_RAIL_MAP:  avs_readdata <= {24'h000000, railMap_q};
                6'h08, 6'h0C, 6'h10, 6'h14:
                    avs_readdata <= {16'h0000, period_q[avs_address[3:2] - 2'h2]};
                `MPK_OFF_MIN_DUTY:  avs_readdata <= {16'h0000, minDuty_q};
                `MPK_OFF_VSTART:    avs_readdata <= {16'h0000, vStart_q};
                `MPK_OFF_VTARGET:   avs_readdata <= {16'h0000, vTarget_q};
                `MPK_OFF_RAMP_STEP: avs_readdata <= {20'h00000, rampStep_q};
                `MPK_OFF_STATUS:    avs_readdata <= {4'h0, refDac, 10'h000,
                                        sync_rectifier_enable, chainEn_q, 1'b0, ss_q};
                default:            avs_readdata <= 32'h00000000;
            endcase
        end
    end
end

// configuration registers and chain kick
always @(posedge core_clk)
begin
    if (rst)
    begin
        railMap_q   <= `MPK_RST_RAIL_MAP;
        for (r = 0; r < 4; r = r + 1)
            period_q[r] <= `MPK_RST_PERIOD;
        minDuty_q   <= `MPK_RST_MIN_DUTY;
        vStart_q    <= 16'h0000;
        vTarget_q   <= 16'h0000;
        rampStep_q  <= `MPK_RST_STEP;
        // [R4] power-up chain reset
        kickPend_q  <= 1'b1;
        chainKick_q <= 1'b0;
        chainEn_q   <= 1'b0;
    end
    else
    begin
        // a kick waits until a running chain has ended, so no stale wave outlives it
        chainKick_q <= kickPend_q && !chainEn_q;
        kickPend_q  <= kickPend_q && chainEn_q;
        if (kickPend_q && !chainEn_q)
            chainEn_q <= 1'b1;
        // [R5] chain disabled after last engine
        else if (sync[NENG])
            chainEn_q <= 1'b0;
        if (avs_write && hit)
        begin
            case ({avs_address[5:2], 2'b00})
                `MPK_OFF_CTRL:
                    // [R4] explicit resync command
                    if (avs_writedata[`MPK_CTRL_RESYNC])
                        kickPend_q <= 1'b1;
                `MPK_OFF_RAIL_MAP:
                begin
                    railMap_q  <= avs_writedata[7:0];
                    // [R4] mapping change restarts chain
                    kickPend_q <= 1'b1;
                end
                6'h08, 6'h0C, 6'h10, 6'h14:
                begin
                    period_q[avs_address[3:2] - 2'h2] <= avs_writedata[15:0];
                    // [R4] frequency change restarts chain
                    kickPend_q <= 1'b1;
                end
                `MPK_OFF_MIN_DUTY:  minDuty_q  <= avs_writedata[15:0];
                `MPK_OFF_VSTART:    vStart_q   <= avs_writedata[15:0];
                `MPK_OFF_VTARGET:   vTarget_q  <= avs_writedata[15:0];
                `MPK_OFF_RAMP_STEP: rampStep_q <= avs_writedata[11:0];
                default: ;
            endcase
        end
    end
end

// phase offsets relative to engine 0 and per-link chain delays
always @*
begin
    fast = 16'hFFFF;
    for (i = 0; i < NENG; i = i + 1)
        if (period_q[railMap_q[2*i+:2]] < fast)
            fast = period_q[railMap_q[2*i+:2]];
    // [R1] rail spacing 3/13 of fastest period
    railGap = ({2'b00, fast} * `MPK_RAIL_NUM) / `MPK_RAIL_DEN;
    ord = 2'h0;
    for (i = 0; i < NENG; i = i + 1)
    begin
        if (i > 0 && railMap_q[2*i+:2] != railMap_q[2*(i-1)+:2])
            ord = ord + 2'h1;
        kIdx = 3'h0;
        nPh  = 3'h0;
        for (j = 0; j < NENG; j = j + 1)
            if (railMap_q[2*j+:2] == railMap_q[2*i+:2])
            begin
                nPh = nPh + 3'h1;
                if (j < i)
                    kIdx = kIdx + 3'h1;
            end
        // [R2] phase k at k/N of rail period
        kp = {2'b00, period_q[railMap_q[2*i+:2]]} * kIdx;
        case (nPh)
            3'h2:    share = kp / 18'h00002;
            3'h3:    share = kp / 18'h00003;
            3'h4:    share = kp / 18'h00004;
            default: share = 18'h00000;
        endcase
        off[i] = railGap * ord + share;
    end
    nextDly[NENG-1] = 18'h00000;
    for (i = 0; i < NENG - 1; i = i + 1)
    begin
        // [R14] a later reset by one own period keeps the same phase
        diff = off[i+1] - off[i];
        if (off[i+1] < off[i])
            diff = diff + {2'b00, period_q[railMap_q[2*(i+1)+:2]]};
        // one tick of syncOut plus one of the counter clear
        nextDly[i] = (diff > 18'h00001) ? diff - 18'h00002 : 18'h00000;
    end
end

assign sync[0] = chainKick_q;

genvar g;
generate
    for (g = 0; g < NENG; g = g + 1)
    begin : engine
        mpk_pwm_engine u_eng
        (
            .clk       (core_clk),
            .rst       (rst),
            .period    (period_q[railMap_q[2*g+:2]]),
            .duty      (dutyEff),
            .nextDelay (nextDly[g]),
            .syncIn    (sync[g]),
            .chainEn   (chainEn_q),
            .syncOut   (sync[g+1]),
            .pwm       (pwmRaw[g])
        );
    end
endgenerate

// saturation flag from the adc pin, counted when stages 2 and 3 agree
always @(posedge core_clk)
begin
    if (rst)
    begin
        satS1_q <= 1'b1;
        satS2_q <= 1'b1;
        satS3_q <= 1'b1;
        sat_q   <= 1'b1;
    end
    else
    begin
        satS1_q <= eadcSat;
        satS2_q <= satS1_q;
        satS3_q <= satS2_q;
        if (satS2_q == satS3_q)
            sat_q <= satS3_q;
    end
end

// clamps on the compensator output
always @*
begin
    // [R7] both clamps at minimum pulse duty
    if (ss_q == SS_KICK)
        dutyEff = minDuty_q;
    // [R9] clamps released, loop closed
    else if (ss_q == SS_CLOSED || ss_q == SS_DONE)
        dutyEff = compDuty;
    else
        dutyEff = 16'h0000;
end

// soft-start sequencer
always @(posedge core_clk)
begin
    if (rst)
    begin
        ss_q                  <= SS_IDLE;
        tick_q                <= 14'h0000;
        idealRamp_q           <= 12'h000;
        refDac                <= 12'h000;
        pwmOut                <= 4'h0;
        sync_rectifier_enable <= 1'b0;
    end
    else
    begin
        tick_q <= tick ? DAC_TICK_CYCLES[13:0] - 14'h0001 : tick_q - 14'h0001;
        // [R12] pwm gated until kick-start
        pwmOut <= (ss_q == SS_IDLE || ss_q == SS_WAIT) ? 4'h0 : pwmRaw;
        case (ss_q)
            SS_IDLE:
                if (avs_write && hit && avs_address[5:2] == 4'h0
                    && avs_writedata[`MPK_CTRL_SS_GO])
                begin
                    idealRamp_q <= 12'h000;
                    ss_q        <= SS_WAIT;
                end
            SS_WAIT:
            begin
                if (tick)
                    idealRamp_q <= idealRamp_q + rampStep_q;
                // [R6] hold off until ramp reaches start voltage
                if ({4'h0, idealRamp_q} >= vStart_q)
                begin
                    // [R8] dac loaded with start voltage
                    refDac                <= vStart_q[11:0];
                    // [R12] rectifier and pwm on
                    sync_rectifier_enable <= 1'b1;
                    ss_q                  <= SS_KICK;
                end
            end
            SS_KICK:
                // [R11] hold until within adc range
                if (!sat_q)
                    ss_q <= SS_CLOSED;
            SS_CLOSED:
                // [R13] one dac code per 10 kHz tick
                if ({4'h0, refDac} == vTarget_q)
                    ss_q <= SS_DONE;
                else if (tick)
                    refDac <= ({4'h0, refDac} < vTarget_q) ? refDac + 12'h001
                                                           : refDac - 12'h001;
            SS_DONE: ;
            default: ss_q <= SS_IDLE;
        endcase
    end
end

endmodule // mpk_top

// File: tb/mpk_top_assertions.sv
// checker for the pwm timing block: bus handshake, enables, dac steps
// assumes it is bound to every instance of the top module
`timescale 1ns/10ps

module mpk_top_assertions
#(
    parameter DAC_TICK_CYCLES = 10000
)
(
    // clock and reset
    input wire        core_clk,
    input wire        rst,
    // register bus
    input wire [5:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // loop and stage
    input wire [15:0] compDuty,
    input wire        eadcSat,
    input wire [11:0] refDac,
    input wire [3:0]  pwmOut,
    input wire        sync_rectifier_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    reg  [11:0] prevDac_q;
    reg  [15:0] gap_q;
    reg         sreP_q;
    reg         stepped_q;
    wire        dacMove = refDac != prevDac_q;
    wire        rdDone  = avs_read && !avs_waitrequest;

    // the jump to the start code is not a step, so pacing starts after it
    always @(posedge core_clk)
    begin
        prevDac_q <= refDac;
        sreP_q    <= sync_rectifier_enable;
        gap_q     <= (rst || dacMove) ? 16'h0000 : gap_q + 16'h0001;
        stepped_q <= rst ? 1'b0 : (dacMove ? sreP_q : stepped_q);
    end

    sequence s_req;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_answer:
    assert property (s_req |=> s_ans) else $error("bus answer not one cycle");
    a_bus_idle:
    assert property (!(avs_read || avs_write) |-> avs_waitrequest)
        else $error("wait dropped without request");
    a_ctrl_blank:
    assert property (rdDone && avs_address[5:2] == 4'h0 |-> avs_readdata == 32'h00000000)
        else $error("control word read not zero");
    a_hole_blank:
    assert property (rdDone && avs_address[5:2] > 4'hA |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_rd_stand:
    assert property ($changed(avs_readdata) |-> rdDone) else $error("read data moved");
    a_sre_gate:
    assert property (!sync_rectifier_enable |-> pwmOut == 4'h0)
        else $error("pwm active without rectifier enable");
    a_sre_keep:
    assert property (sync_rectifier_enable |=> sync_rectifier_enable)
        else $error("rectifier enable dropped");
    a_dac_step:
    assert property (dacMove && sreP_q |->
        (refDac == prevDac_q + 12'h001) || (refDac == prevDac_q - 12'h001))
        else $error("dac step not one code");
    a_dac_pace:
    assert property (dacMove && sreP_q && stepped_q |-> gap_q == DAC_TICK_CYCLES - 1)
        else $error("dac step spacing wrong");
endmodule // mpk_top_assertions

bind mpk_top mpk_top_assertions #(.DAC_TICK_CYCLES(DAC_TICK_CYCLES)) chk (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .compDuty(compDuty), .eadcSat(eadcSat),
    .refDac(refDac), .pwmOut(pwmOut), .sync_rectifier_enable(sync_rectifier_enable));

// File: tb/mpk_stage_model.sv
// power stage stand-in: output charges while switching, error adc desaturates
// assumes pwmOut and rectifier enable come straight from the top module
`timescale 1ns/10ps

module mpk_stage_model
#(
    parameter PULSES_TO_RANGE = 4
)
(
    // clock and reset
    input wire       core_clk,
    input wire       rst,
    // from the block
    input wire [3:0] pwmOut,
    input wire       sync_rectifier_enable,
    // to the block
    output reg       eadcSat
);
    reg       pwmPrev_q;
    reg [7:0] pulseCnt_q;

    initial eadcSat = 1'b1;

    always @(posedge core_clk)
    begin
        pwmPrev_q <= pwmOut[0];
        if (rst || !sync_rectifier_enable)
            pulseCnt_q <= 8'h00;
        else if (pwmOut[0] && !pwmPrev_q && pulseCnt_q < PULSES_TO_RANGE)
            pulseCnt_q <= pulseCnt_q + 8'h01;
        eadcSat <= rst || (pulseCnt_q < PULSES_TO_RANGE);
    end
endmodule // mpk_stage_model

// File: tb/tb_multirail_pwm_phase_kickstart.sv
// bench for the pwm timing block: registers, soft-start, phase spreading
// assumes the stage model desaturates the error adc after a few pulses
`timescale 1ns/10ps

module tb_multirail_pwm_phase_kickstart;
    localparam TICK = 20;
    localparam [35:0] ADR = {6'h3C, 6'h00, 6'h24, 6'h18, 6'h08, 6'h04};
    localparam [47:0] VAL = {8'h00, 8'h00, 8'h01, 8'h04, 8'hC8, 8'hE4};

    reg         core_clk      = 1'b0;
    reg         rst           = 1'b1;
    reg  [5:0]  avs_address   = 6'h00;
    reg         avs_read      = 1'b0;
    reg         avs_write     = 1'b0;
    reg  [31:0] avs_writedata = 32'h00000000;
    reg  [15:0] compDuty      = 16'h0020;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire        eadcSat;
    wire [11:0] refDac;
    wire [3:0]  pwmOut;
    wire        sync_rectifier_enable;
    integer     err_total = 0;
    integer     checks    = 0;
    integer     d;
    reg  [31:0] q;
    time        t0;

    always #5 core_clk = ~core_clk;

    mpk_top #(.DAC_TICK_CYCLES(TICK)) DUT (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .compDuty(compDuty), .eadcSat(eadcSat),
        .refDac(refDac), .pwmOut(pwmOut), .sync_rectifier_enable(sync_rectifier_enable));

    mpk_stage_model #(.PULSES_TO_RANGE(4)) stage (
        .core_clk(core_clk), .rst(rst), .pwmOut(pwmOut),
        .sync_rectifier_enable(sync_rectifier_enable), .eadcSat(eadcSat));

    task final_report;
    begin
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask

    task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("mismatch %0s expected %h seen %h", name, exp, got);
        end
    end
    endtask

    // one access; returns on the edge after release so the next may follow
    // a hung slave is left to the watchdog
    task bus(input w, input [5:0] a, input [31:0] dat);
    begin
        avs_address   <= a;
        avs_writedata <= dat;
        avs_read      <= !w;
        avs_write     <= w;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    end
    endtask

    task width;
    begin
        wait (pwmOut[0] === 1'b0);
        wait (pwmOut[0] === 1'b1);
        t0 = $time;
        wait (pwmOut[0] === 1'b0);
        d = ($time - t0) / 10;
    end
    endtask

    task gap(input integer i);
    begin
        wait (pwmOut[0] === 1'b0);
        wait (pwmOut[0] === 1'b1);
        t0 = $time;
        wait (pwmOut[i] === 1'b0);
        wait (pwmOut[i] === 1'b1);
        d = ($time - t0) / 10;
    end
    endtask

    task t_regs;
        integer i;
    begin
        bus(1'b1, 6'h3C, 32'hFFFFFFFF);
        bus(1'b1, 6'h00, 32'h00000002);
        for (i = 0; i < 6; i = i + 1)
        begin
            bus(1'b0, ADR[6*i+:6], 32'h00000000);
            chk("reset value", {24'h000000, VAL[8*i+:8]}, q);
        end
        bus(1'b0, 6'h28, 32'h00000000);
        chk("status idle", 32'h00000000, {q[5], q[2:0]});
    end
    endtask

    // minimum pulse kept short against the period for gentle inrush
    task t_soft;
    begin
        bus(1'b1, 6'h1C, 32'h00000008);
        bus(1'b1, 6'h20, 32'h0000000D);
        t0 = $time;
        bus(1'b1, 6'h00, 32'h00000001);
        chk("sre idle", 32'h0, sync_rectifier_enable);
        chk("pwm idle", 32'h0, pwmOut);
        wait (sync_rectifier_enable === 1'b1);
        chk("ramp wait", 32'h1, ($time - t0) / 10 >= 7 * TICK);
        @(posedge core_clk);
        chk("dac start", 32'h8, refDac);
        width;
        width;
        chk("kick width", 32'h4, d);
        @(refDac);
        t0 = $time;
        @(refDac);
        chk("dac pace", TICK, ($time - t0) / 10);
        wait (refDac === 12'h00D);
        width;
        chk("loop width", 32'h20, d);
        @(posedge core_clk);
        bus(1'b0, 6'h28, 32'h00000000);
        chk("state done", 32'h4, q[2:0]);
        chk("dac final", 32'hD, q[27:16]);
    end
    endtask

    // a period write restarts the chain before the map write does
    task t_phase(input [7:0] map, input [15:0] per, input [23:0] exp);
        integer i;
    begin
        bus(1'b1, 6'h08, {16'h0000, per});
        bus(1'b0, 6'h28, 32'h00000000);
        chk("chain busy", 32'h1, q[4]);
        bus(1'b1, 6'h04, {24'h000000, map});
        repeat (800) @(posedge core_clk);
        bus(1'b0, 6'h28, 32'h00000000);
        chk("chain idle", 32'h0, q[4]);
        for (i = 1; i < 4; i = i + 1)
        begin
            gap(i);
            chk("phase", exp[8*i-8+:8], d);
        end
        @(posedge core_clk);
    end
    endtask

    initial
    begin
        #400000;
        err_total = err_total + 1;
        final_report;
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_regs;
        t_soft;
        t_phase(8'hE4, 16'h00C8, {8'd138, 8'd92, 8'd46});
        t_phase(8'h50, 16'h00C8, {8'd146, 8'd46, 8'd100});
        t_phase(8'h00, 16'h00A0, {8'd120, 8'd80, 8'd40});
        final_report;
    end
endmodule // tb_multirail_pwm_phase_kickstart
